//--- rtl/phy_pins_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PHY_PINS_REGS_SVH
`define PHY_PINS_REGS_SVH
`define REG_BASIC_CTRL      5'h00
`define REG_IRQ_CTRL_STAT   5'h1B
`define REG_LED_CTRL        5'h1E
`define REG_PHY_CTRL2       5'h1F
`define REG_MII_MODE        5'h10
`define BIT_DUPLEX          8
`define BIT_AUTONEG         12
`define BIT_ISOLATE         10
`define BIT_IRQ_POL         9
`define FLD_LED_MODE_HI     15
`define FLD_LED_MODE_LO     14
`define RST_LED_CTRL        16'h0000
`define RST_PHY_CTRL2       16'h0000
`define RST_MII_MODE        16'h0001
`define CLK_PERIOD_PS       5000
`define BLINK_TIME_US       100
`define BLINK_CYCLES        ((`BLINK_TIME_US * 1000000) / `CLK_PERIOD_PS)
`endif

//--- rtl/phy_pins_pkg.sv
// Types shared by the pin logic
`default_nettype none
package phy_pins_pkg;
   typedef struct packed {
      logic       mgmt_address_bit2_strap;
      logic       duplex;
      logic [2:0] cfg;
      logic       isolate;
      logic       autoneg_enable_strap;
   } strap_type;
   typedef struct packed {
      logic [3:0] rxd;
      logic       rx_dv;
      logic       rx_er;
      logic       col;
      logic       crs;
   } rx_side_type;
   typedef struct packed {
      logic       tx_en;
      logic [3:0] txd;
   } tx_side_type;
   typedef enum logic [1:0] {
      LED_LINK_ACT = 2'h0,
      LED_LINK     = 2'h1,
      LED_RSVD2    = 2'h2,
      LED_RSVD3    = 2'h3
   } led_mode_type;
   typedef enum logic [2:0] {
      ST_STRAP = 3'b001,
      ST_RUN   = 3'b010,
      ST_HOLD  = 3'b100
   } phase_type;
endpackage
`default_nettype wire

//--- rtl/phy_pin_strap_led_logic.sv
// Pin logic: strap capture, MII/RMII pin muxing, interrupt and LINK_LED_OUT output
// Function
// - Strap receive data bit 1 into address bit 2
// - Strap receive data bit 0 into duplex
// - Strap valid, collision, carrier into configuration bits
// - Strap receive error pin into isolate mode
// - Strap LINK_LED_OUT pin into auto-negotiation enable
// - Strap pins input during reset and the strap and hold phases, output otherwise
// - Interrupt control and status register at 1Bh
// - Register 1Fh bit 9 sets interrupt polarity
// - Register 1Eh bits 15:14 select LINK_LED_OUT mode
// - Mode 00 link plus activity, 01 link only
// - Valid pin is data valid or carrier/valid
// - MII mode drives receive and transmit clocks
// - MII drives collision and carrier; RMII holds both low
// - Receive error driven in both modes
// - RMII gives two bits per valid clock
// - Transmit data ignored while enable low
`default_nettype none
`include "phy_pins_regs.svh"
module phy_pin_strap_led_logic #(
   parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES
) (
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   input  wire logic                     link_clk_in,
   input  wire logic [4:0]               reg_addr_in,
   input  wire logic [15:0]              reg_wdata_in,
   input  wire logic                     reg_wr_in,
   input  wire logic                     reg_rd_in,
   output logic      [15:0]              reg_rdata_out,
   input  wire phy_pins_pkg::rx_side_type core_rx_in,
   output phy_pins_pkg::tx_side_type     core_tx_out,
   output logic                          core_tx_valid_out,
   input  wire logic                     link_up_in,
   input  wire logic                     activity_in,
   input  wire logic [7:0]               irq_events_in,
   input  wire phy_pins_pkg::rx_side_type pin_rx_in,
   output phy_pins_pkg::rx_side_type     pin_rx_out,
   output logic      [7:0]               pin_rx_oe_out,
   input  wire phy_pins_pkg::tx_side_type pin_tx_in,
   input  wire logic                     link_led_in,
   output logic                          link_led_out,
   output logic                          link_led_oe_out,
   output logic                          rx_clk_out,
   output logic                          tx_clk_out,
   output logic                          irq_out,
   output phy_pins_pkg::strap_type       strap_out,
   output logic      [4:0]               mgmt_address_out,
   output logic                          isolate_out
);
   import phy_pins_pkg::*;

   phase_type    phase_r;
   phase_type    phase_nxt;
   strap_type    strap_r;
   strap_type    strap_meta_r;
   strap_type    strap_sync_r;
   rx_side_type  rx_r;
   logic [7:0]   rx_oe_r;
   tx_side_type  tx_meta_r;
   tx_side_type  tx_sync_r;
   tx_side_type  tx_r;
   logic         tx_valid_r;
   logic [2:0]   lclk_sync_r;
   logic         rx_clk_r;
   logic         tx_clk_r;
   logic [15:0]  basic_ctrl_r;
   logic [15:0]  led_ctrl_r;
   logic [15:0]  ctrl2_r;
   logic [15:0]  mode_r;
   logic [7:0]   irq_en_r;
   logic [7:0]   irq_stat_r;
   logic [15:0]  rdata_r;
   logic         irq_r;
   logic         led_r;
   logic         led_oe_r;
   logic [31:0]  blink_cnt_r;
   logic         blink_r;

   // Phase, mode and register strobe decode
   wire          strapping  = (phase_r == ST_STRAP);
   wire          mii_mode   = mode_r[0];
   wire          lclk_rise  = lclk_sync_r[1] & ~lclk_sync_r[2];
   wire          wr_basic   = reg_wr_in && (reg_addr_in == `REG_BASIC_CTRL);
   wire          wr_irq     = reg_wr_in && (reg_addr_in == `REG_IRQ_CTRL_STAT);
   wire          rd_irq     = reg_rd_in && (reg_addr_in == `REG_IRQ_CTRL_STAT);
   wire          wr_led     = reg_wr_in && (reg_addr_in == `REG_LED_CTRL);
   wire          wr_ctrl2   = reg_wr_in && (reg_addr_in == `REG_PHY_CTRL2);
   wire          wr_mode    = reg_wr_in && (reg_addr_in == `REG_MII_MODE);
   wire led_mode_type led_mode = led_mode_type'(
      led_ctrl_r[`FLD_LED_MODE_HI:`FLD_LED_MODE_LO]);
   wire          irq_pend   = |(irq_stat_r & irq_en_r);
   wire          blink_wrap = (blink_cnt_r >= BLINK_CYCLES - 1);
   wire [7:0]    irq_stat_nxt = (rd_irq ? 8'h00 : irq_stat_r) | irq_events_in;

   // Strap map from the shared pins
   strap_type    strap_pins;
   assign strap_pins.mgmt_address_bit2_strap = pin_rx_in.rxd[1];
   assign strap_pins.duplex                  = pin_rx_in.rxd[0];
   assign strap_pins.cfg = {pin_rx_in.rx_dv, pin_rx_in.crs,
                            pin_rx_in.col};
   assign strap_pins.isolate                 = pin_rx_in.rx_er;
   assign strap_pins.autoneg_enable_strap    = link_led_in;

   // Reserved modes leave the LED dark
   function automatic logic led_level(input led_mode_type m,
                                      input logic lnk, input logic act,
                                      input logic blk);
      case (m)
         LED_LINK_ACT: led_level = ~lnk ? 1'b1 : (act ? blk : 1'b0);
         LED_LINK:     led_level = ~lnk;
         default:      led_level = 1'b1;
      endcase
   endfunction

   // Strap for one cycle, hold one, then run
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         ST_STRAP: phase_nxt = ST_HOLD;
         ST_HOLD:  phase_nxt = ST_RUN;
         ST_RUN:   phase_nxt = ST_RUN;
         default:  phase_nxt = ST_STRAP;
      endcase
   end

   // Synchroniser runs through reset so pin levels are settled at release
   always_ff @(posedge clk_in) begin
      strap_meta_r <= strap_pins;
      strap_sync_r <= strap_meta_r;
   end

   // Pins float with pulls while reset holds; strap caught after release
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         phase_r      <= ST_STRAP;
         strap_r      <= '0;
      end else begin
         phase_r      <= phase_nxt;
         if (phase_r == ST_HOLD) begin
            strap_r <= strap_sync_r;
         end
      end
   end

   // Two-stage synchronisers for link clock and MAC pins
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         lclk_sync_r <= 3'h0;
         tx_meta_r   <= '0;
         tx_sync_r   <= '0;
      end else begin
         lclk_sync_r <= {lclk_sync_r[1:0], link_clk_in};
         tx_meta_r   <= pin_tx_in;
         tx_sync_r   <= tx_meta_r;
      end
   end

   // Transmit side sampled on link clock rising edges
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         tx_r       <= '0;
         tx_valid_r <= 1'b0;
      end else if (lclk_rise) begin
         tx_valid_r <= tx_sync_r.tx_en;
         tx_r.tx_en <= tx_sync_r.tx_en;
         if (tx_sync_r.tx_en) begin
            tx_r.txd <= mii_mode ? tx_sync_r.txd
                                 : {2'h0, tx_sync_r.txd[1:0]};
         end else begin
            tx_r.txd <= 4'h0;
         end
      end
   end

   // Receive side, driven only in the run phase
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rx_r     <= '0;
         rx_oe_r  <= 8'h00;
         rx_clk_r <= 1'b0;
         tx_clk_r <= 1'b0;
      end else begin
         rx_oe_r  <= strapping ? 8'h00 : 8'hFF;
         rx_clk_r <= mii_mode & lclk_sync_r[1];
         tx_clk_r <= mii_mode & lclk_sync_r[1];
         if (lclk_rise) begin
            rx_r.rx_er <= core_rx_in.rx_er;
            if (mii_mode) begin
               rx_r.rxd   <= core_rx_in.rxd;
               rx_r.rx_dv <= core_rx_in.rx_dv;
               rx_r.col   <= core_rx_in.col;
               rx_r.crs   <= core_rx_in.crs;
            end else begin
               // Upper data bits and MII-only pins held low
               rx_r.rxd   <= {2'h0, core_rx_in.rxd[1:0]};
               rx_r.rx_dv <= core_rx_in.crs | core_rx_in.rx_dv;
               rx_r.col   <= 1'b0;
               rx_r.crs   <= 1'b0;
            end
         end
      end
   end

   // Register file; strap values load control bits at release
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         basic_ctrl_r <= 16'h0000;
         led_ctrl_r   <= `RST_LED_CTRL;
         ctrl2_r      <= `RST_PHY_CTRL2;
         mode_r       <= `RST_MII_MODE;
         irq_en_r     <= 8'h00;
         irq_stat_r   <= 8'h00;
      end else begin
         // Event in a read cycle survives the clear
         irq_stat_r <= irq_stat_nxt;
         // Straps override a write in the hold cycle
         if (phase_r == ST_HOLD) begin
            basic_ctrl_r[`BIT_DUPLEX]  <= strap_sync_r.duplex;
            basic_ctrl_r[`BIT_AUTONEG] <=
               strap_sync_r.autoneg_enable_strap;
            basic_ctrl_r[`BIT_ISOLATE] <= strap_sync_r.isolate;
         end else if (wr_basic) begin
            basic_ctrl_r <= reg_wdata_in;
         end
         if (wr_irq) begin
            irq_en_r <= reg_wdata_in[15:8];
         end
         if (wr_led) begin
            led_ctrl_r <= reg_wdata_in;
         end
         if (wr_ctrl2) begin
            ctrl2_r <= reg_wdata_in;
         end
         if (wr_mode) begin
            mode_r <= {15'h0000, reg_wdata_in[0]};
         end
      end
   end

   // Read data stand one cycle after the strobe, else zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_BASIC_CTRL:    rdata_r <= basic_ctrl_r;
            `REG_IRQ_CTRL_STAT: rdata_r <= {irq_en_r, irq_stat_r};
            `REG_LED_CTRL:      rdata_r <= led_ctrl_r;
            `REG_PHY_CTRL2:     rdata_r <= ctrl2_r;
            `REG_MII_MODE:      rdata_r <= mode_r;
            default:            rdata_r <= 16'h0000;
         endcase
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   // Activity blink divider and LED/interrupt pins
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         blink_cnt_r <= 32'h0;
         blink_r     <= 1'b0;
         led_r       <= 1'b1;
         led_oe_r    <= 1'b0;
         irq_r       <= 1'b1;
      end else begin
         blink_cnt_r <= blink_wrap ? 32'h0 : blink_cnt_r + 32'h1;
         // Divider wrap toggles the activity blink
         if (blink_wrap) begin
            blink_r <= ~blink_r;
         end
         led_oe_r <= ~strapping;
         led_r    <= led_level(led_mode, link_up_in, activity_in,
                               blink_r);
         // Polarity bit picks the asserted level
         irq_r    <= ctrl2_r[`BIT_IRQ_POL] ? irq_pend : ~irq_pend;
      end
   end

   // Pins and status straight from registers
   assign reg_rdata_out     = rdata_r;
   assign core_tx_out       = tx_r;
   assign core_tx_valid_out = tx_valid_r;
   assign pin_rx_out        = rx_r;
   assign pin_rx_oe_out     = rx_oe_r;
   assign link_led_out      = led_r;
   assign link_led_oe_out   = led_oe_r;
   assign rx_clk_out        = rx_clk_r;
   assign tx_clk_out        = tx_clk_r;
   assign irq_out           = irq_r;
   assign strap_out         = strap_r;
   assign mgmt_address_out  = {2'h0, strap_r.mgmt_address_bit2_strap, 2'h0};
   assign isolate_out       = basic_ctrl_r[`BIT_ISOLATE];
endmodule // phy_pin_strap_led_logic
`default_nettype wire

//--- verif/phy_pins_chk_assertions.sv
// Port assertions for the pin logic
`default_nettype none
module phy_pins_chk (
   input wire logic                      clk_in,
   input wire logic                      reset_in,
   input wire logic [7:0]                pin_rx_oe_out,
   input wire logic                      link_led_oe_out,
   input wire phy_pins_pkg::strap_type   strap_out,
   input wire logic [4:0]                mgmt_address_out,
   input wire logic                      isolate_out,
   input wire logic                      rx_clk_out,
   input wire logic                      tx_clk_out,
   input wire phy_pins_pkg::tx_side_type core_tx_out,
   input wire logic                      core_tx_valid_out,
   input wire logic                      irq_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import phy_pins_pkg::*;
   logic [2:0] age_r;
   logic [2:0] age_nxt;
   // Cycles since reset release, saturating
   assign age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         age_r <= 3'h0;
      end else begin
         age_r <= age_nxt;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_pins_in;
      pin_rx_oe_out == 8'h00 && !link_led_oe_out;
   endsequence
   sequence s_pins_out;
      pin_rx_oe_out == 8'hFF && link_led_oe_out;
   endsequence
   property p_strap_oe;
      $fell(reset_in) |-> s_pins_in ##4 s_pins_out;
   endproperty
   property p_hold;
      age_r == 3'h7 |-> $stable(strap_out);
   endproperty
   property p_addr;
      age_r == 3'h7 |->
         mgmt_address_out == {2'h0, strap_out.mgmt_address_bit2_strap, 2'h0};
   endproperty
   property p_iso;
      age_r == 3'h5 |-> isolate_out == strap_out.isolate;
   endproperty
   property p_clk;
      $rose(rx_clk_out) |-> tx_clk_out ##[3:7] !rx_clk_out;
   endproperty
   property p_tx_gate;
      !core_tx_out.tx_en |-> core_tx_out.txd == 4'h0;
   endproperty
   property p_tx_valid;
      core_tx_valid_out == core_tx_out.tx_en;
   endproperty
   property p_irq_idle;
      $fell(reset_in) |-> irq_out [*4];
   endproperty
   a_strap_oe: assert property (p_strap_oe)
      else $error("strap pin enables wrong");
   a_hold: assert property (p_hold)
      else $error("straps moved");
   a_addr: assert property (p_addr)
      else $error("address wrong");
   a_iso: assert property (p_iso)
      else $error("isolate wrong");
   a_clk: assert property (p_clk)
      else $error("link clocks wrong");
   a_tx_gate: assert property (p_tx_gate)
      else $error("tx data not gated");
   a_tx_valid: assert property (p_tx_valid)
      else $error("tx valid wrong");
   a_irq_idle: assert property (p_irq_idle)
      else $error("irq not idle high");
endmodule // phy_pins_chk
bind phy_pin_strap_led_logic phy_pins_chk chk (
   .clk_in(clk_in), .reset_in(reset_in), .pin_rx_oe_out(pin_rx_oe_out),
   .link_led_oe_out(link_led_oe_out), .strap_out(strap_out),
   .mgmt_address_out(mgmt_address_out), .isolate_out(isolate_out),
   .rx_clk_out(rx_clk_out), .tx_clk_out(tx_clk_out),
   .core_tx_out(core_tx_out), .core_tx_valid_out(core_tx_valid_out),
   .irq_out(irq_out));
`default_nettype wire

//--- verif/mac_model.sv
// Transmit side of the MAC facing the pin logic
`default_nettype none
module mac_model (
   input  wire logic                 link_clk_in,
   input  wire logic                 send_in,
   input  wire logic                 rmii_in,
   input  wire logic [3:0]           nib_in,
   output phy_pins_pkg::tx_side_type tx_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import phy_pins_pkg::*;
   initial tx_out = '0;
   // Undriven data lines flip each clock
   always @(negedge link_clk_in) begin
      tx_out.tx_en <= send_in;
      tx_out.txd[1:0] <= send_in ? nib_in[1:0] : ~tx_out.txd[1:0];
      tx_out.txd[3:2] <= (send_in && !rmii_in) ? nib_in[3:2]
         : ~tx_out.txd[3:2];
   end
endmodule // mac_model
`default_nettype wire

//--- verif/phy_pin_strap_led_logic_test.sv
// Self-checking bench for the pin logic
`default_nettype none
module phy_pin_strap_led_logic_test;
   timeunit 1ns;
   timeprecision 100ps;
   import phy_pins_pkg::*;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        link_clk = 1'b0;
   logic [4:0]  reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr_s = 1'b0;
   logic        reg_rd_s = 1'b0;
   logic [7:0]  core_rx = 8'h00;
   logic [7:0]  straps = 8'h00;
   logic [7:0]  irq_ev = 8'h00;
   logic [3:0]  nib = 4'h0;
   logic        link_up = 1'b0;
   logic        activity = 1'b0;
   logic        led_strap = 1'b0;
   logic        send = 1'b0;
   logic        rmii = 1'b0;
   logic [15:0] rdata;
   logic [7:0]  pin_oe;
   logic [6:0]  strap_exp;
   logic [15:0] rd0_exp;
   logic        led_out, led_oe, led_lvl, rx_clk, irq, tx_vld, tx_clk, iso;
   logic [4:0]  mgmt_addr;
   rx_side_type pin_rx, pin_lvl;
   tx_side_type pin_tx, core_tx;
   strap_type   strap;
   int          err_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   always #2.5 clk_in = ~clk_in;
   always #24 link_clk = ~link_clk;
   // Shared pins: device drive when enabled, else strap level
   assign pin_lvl = (pin_rx & pin_oe) | (straps & ~pin_oe);
   assign led_lvl = led_oe ? led_out : led_strap;
   assign strap_exp = {straps[5:3], straps[0], straps[1], straps[2],
                       led_strap};
   assign rd0_exp = {3'h0, led_strap, 1'b0, straps[2], 1'b0, straps[4], 8'h00};
   phy_pin_strap_led_logic #(.BLINK_CYCLES(4)) uut (
      .clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr_s), .reg_rd_in(reg_rd_s), .reg_rdata_out(rdata),
      .core_rx_in(core_rx), .core_tx_out(core_tx),
      .core_tx_valid_out(tx_vld), .link_up_in(link_up),
      .activity_in(activity), .irq_events_in(irq_ev),
      .pin_rx_in(pin_lvl), .pin_rx_out(pin_rx), .pin_rx_oe_out(pin_oe),
      .pin_tx_in(pin_tx), .link_led_in(led_lvl), .link_led_out(led_out),
      .link_led_oe_out(led_oe), .rx_clk_out(rx_clk), .tx_clk_out(tx_clk),
      .irq_out(irq), .strap_out(strap), .mgmt_address_out(mgmt_addr),
      .isolate_out(iso));
   mac_model mac (.link_clk_in(link_clk), .send_in(send), .rmii_in(rmii),
      .nib_in(nib), .tx_out(pin_tx));
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_s <= 1'b1;
      @(posedge clk_in);
      reg_wr_s <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] m,
                         input logic [15:0] e);
      @(posedge clk_in);
      reg_addr <= a;
      reg_rd_s <= 1'b1;
      @(posedge clk_in);
      reg_rd_s <= 1'b0;
      @(negedge clk_in);
      chk(rdata & m, e);
   endtask
   task automatic do_reset(input logic [7:0] p, input logic l);
      @(posedge clk_in);
      straps <= p;
      led_strap <= l;
      reset_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (8) @(negedge clk_in);
   endtask
   task automatic watch(input logic w, input logic [1:0] e);
      logic [1:0] seen;
      seen = 2'h0;
      repeat (24) begin
         @(negedge clk_in);
         seen = seen | (w ? {rx_clk & tx_clk, ~(rx_clk | tx_clk)}
                          : {led_out, ~led_out});
      end
      chk(16'(seen), 16'(e));
   endtask
   task automatic led_case(input logic [1:0] m, input logic l,
                           input logic a, input logic [1:0] e);
      reg_wr(5'h1E, {m, 14'h0000});
      link_up <= l;
      activity <= a;
      repeat (4) @(negedge clk_in);
      watch(1'b0, e);
   endtask
   task automatic irq_pulse;
      @(posedge clk_in);
      irq_ev <= 8'h81;
      @(posedge clk_in);
      irq_ev <= 8'h00;
      repeat (3) @(negedge clk_in);
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      for (int i = 0; i < 2; i++) begin
         do_reset(i[0] ? 8'hCA : 8'h35, i[0]);
         chk(16'(strap), 16'(strap_exp));
         chk(16'(pin_oe), 16'h00FF);
         chk(16'(led_oe), 16'h0001);
         chk(16'(mgmt_addr), 16'({straps[5], 2'h0}));
         chk(16'(iso), 16'(straps[2]));
         rd_chk(5'h00, 16'h1500, rd0_exp);
      end
      reg_wr(5'h00, 16'h0400);
      rd_chk(5'h00, 16'hFFFF, 16'h0400);
      chk(16'(iso), 16'h0001);
      $display("straps done");
      rd_chk(5'h1E, 16'hFFFF, 16'h0000);
      rd_chk(5'h1F, 16'hFFFF, 16'h0000);
      rd_chk(5'h10, 16'hFFFF, 16'h0001);
      rd_chk(5'h05, 16'hFFFF, 16'h0000);
      led_case(2'h1, 1'b0, 1'b0, 2'h2);
      led_case(2'h1, 1'b1, 1'b1, 2'h1);
      led_case(2'h0, 1'b0, 1'b0, 2'h2);
      led_case(2'h0, 1'b1, 1'b0, 2'h1);
      led_case(2'h0, 1'b1, 1'b1, 2'h3);
      led_case(2'h2, 1'b1, 1'b1, 2'h2);
      led_case(2'h3, 1'b1, 1'b1, 2'h2);
      $display("led done");
      reg_wr(5'h1B, 16'hFF00);
      irq_pulse();
      chk(16'(irq), 16'h0000);
      rd_chk(5'h1B, 16'hFFFF, 16'hFF81);
      repeat (3) @(negedge clk_in);
      chk(16'(irq), 16'h0001);
      reg_wr(5'h1F, 16'h0200);
      repeat (3) @(negedge clk_in);
      chk(16'(irq), 16'h0000);
      irq_pulse();
      chk(16'(irq), 16'h0001);
      rd_chk(5'h1B, 16'h00FF, 16'h0081);
      reg_wr(5'h1B, 16'h0000);
      irq_pulse();
      chk(16'(irq), 16'h0000);
      $display("irq done");
      @(posedge clk_in);
      core_rx <= 8'hAB;
      send <= 1'b1;
      nib <= 4'h9;
      repeat (24) @(negedge clk_in);
      chk(16'(pin_rx), 16'h00AB);
      chk(16'(core_tx), 16'h0019);
      chk(16'(tx_vld), 16'h0001);
      watch(1'b1, 2'h3);
      @(posedge clk_in);
      send <= 1'b0;
      repeat (24) @(negedge clk_in);
      chk(16'(core_tx), 16'h0000);
      chk(16'(tx_vld), 16'h0000);
      reg_wr(5'h10, 16'h0000);
      rmii <= 1'b1;
      core_rx <= 8'h6C;
      send <= 1'b1;
      nib <= 4'hF;
      repeat (24) @(negedge clk_in);
      chk(16'(pin_rx & 8'h3C), 16'h002C);
      chk(16'(core_tx), 16'h0013);
      watch(1'b1, 2'h1);
      $display("data done");
      close_out();
   end
endmodule // phy_pin_strap_led_logic_test
`default_nettype wire
